// file: core/rct_top.v
// reset cause flags, start-up delay sequencing and reset-state loading
//
// How it works
// RQ1: cause register holds power-on and brown-out bits naming the last reset.
// RQ2: brown-out bit undefined after power-on, cleared by each brown-out.
// RQ3: software sets brown-out bit after power-on, reads zero as brown-out.
// RQ4: with brown-out detection off the brown-out bit carries no meaning.
// RQ5: power-on bit cleared by power-on reset, kept through all other resets.
// RQ6: software writes one to power-on bit after each power-on reset.
// RQ7: crystal modes add 1024 clock periods after power-up timer and on wake; the code skips this for a low-power crystal fed from the timer1 oscillator.
// RQ8: pin reset while running leaves all four cause flags unchanged.
// RQ9: pin reset in sleep sets watchdog flag, clears sleep flag, keeps others.
// RQ10: power-on and brown-out set watchdog and sleep flags, clear own bit.
// RQ11: watchdog reset clears watchdog flag; watchdog wake clears both flags.
// RQ12: cause register bits 5,4,1,0; 01qq on power-on/brown-out, 0uuu else.
// RQ13: resets load pc low byte zero and clear ports; wake adds one.
// RQ14: software mode lets the software enable bit switch the detector.
// RQ15: power-up timer holds reset 64 ms on low-frequency oscillator ticks.
// RQ16: power-up timer runs when its disable input is low, skipped when high.
// RQ17: cause flags change only on resets, wakes, sleep and watchdog-clear commands or software writes.
// RQ18: new brown-out during the delay restarts it, reset held throughout.
`timescale 1ns/10ps
`include "rct_consts.vh"
module rct_top #(
	parameter PWRT_TICKS = `RCT_TPWRT_MS * `RCT_LFOSC_HZ / 1000,
	parameter OST_TICKS = `RCT_OST_PERIODS
) (
	// clock and power-on reset
	input wire clk_i,
	input wire rst_i,
	// register port
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// configuration
	input wire [1:0] brownout_enable_sel_i,
	input wire powerup_delay_disable_i,
	input wire [2:0] osc_mode_i,
	input wire timer1_osc_input_i,
	// time bases
	input wire lf_tick_i,
	input wire osc_tick_i,
	// reset and wake sources
	input wire brownout_below_i,
	input wire external_reset_pin_n_i,
	input wire watchdog_timeout_i,
	input wire wake_irq_i,
	// processor requests
	input wire sleep_cmd_i,
	input wire watchdog_clear_i,
	input wire [7:0] pc_low_i,
	// reset and processor control
	output reg chip_reset_o,
	output reg reset_state_load_o,
	output reg pc_load_o,
	output reg [7:0] pc_low_byte_o,
	output reg brownout_detect_en_o,
	output reg ultra_low_power_wake_en_o,
	// interrupt
	output reg irq_o
);

localparam [2:0] ST_BOOT = 3'h0;
localparam [2:0] ST_BOR = 3'h1;
localparam [2:0] ST_PWRT = 3'h2;
localparam [2:0] ST_OST = 3'h3;
localparam [2:0] ST_RUN = 3'h4;
localparam [2:0] ST_SLEEP = 3'h5;
localparam [2:0] ST_WAKE = 3'h6;
localparam [2:0] ST_PIN = 3'h7;
localparam [10:0] PWRT_CNT = PWRT_TICKS[10:0];
localparam [10:0] OST_CNT = OST_TICKS[10:0];
localparam NI = `RCT_IRQ_BITS;

reg [2:0] state;
reg poweron_flag;
reg brownout_flag;
reg software_brownout_enable;
reg watchdog_expired_flag;
reg sleep_entered_flag;
reg pwrt_start;
reg ost_start;
reg [NI-1:0] events;
wire pwrt_done;
wire ost_done;
wire [NI-1:0] irq_status;
wire [NI-1:0] irq_mask;
wire irq_line;
wire crystal;
wire ost_need;
wire pwrt_en;
wire pin_low;
wire brownout_active;
wire wr_cause;
wire wr_irq_status;
wire wr_irq_mask;
reg next_bor_en;

// the pin is active low and already synchronous
assign pin_low = ~external_reset_pin_n_i;
assign pwrt_en = ~powerup_delay_disable_i; // see RQ16
assign crystal = (osc_mode_i == `RCT_OSC_LP) || (osc_mode_i == `RCT_OSC_XT) ||
	(osc_mode_i == `RCT_OSC_HS);
// a low-power crystal fed from the timer1 oscillator needs no start-up wait
assign ost_need = crystal &&
	!((osc_mode_i == `RCT_OSC_LP) && timer1_osc_input_i); // see RQ7
assign brownout_active = brownout_below_i & brownout_detect_en_o;
assign wr_cause = wr_i && (addr_i == `RCT_ADDR_CAUSE_FLAGS);
assign wr_irq_status = wr_i && (addr_i == `RCT_ADDR_IRQ_STATUS);
assign wr_irq_mask = wr_i && (addr_i == `RCT_ADDR_IRQ_MASK);

// power-up timer on the low-frequency oscillator
rct_delay_cnt #(
	.W(11),
	.COUNT(PWRT_CNT)
) u_pwrt (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.start_i(pwrt_start),
	.tick_i(lf_tick_i),
	.busy_o(),
	.done_o(pwrt_done)
); // see RQ15

// oscillator start-up wait counted in oscillator periods
rct_delay_cnt #(
	.W(11),
	.COUNT(OST_CNT)
) u_ost (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.start_i(ost_start),
	.tick_i(osc_tick_i),
	.busy_o(),
	.done_o(ost_done)
);

rct_irq #(
	.N(NI)
) u_irq (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.set_i(events),
	.wr_status_i(wr_irq_status),
	.wr_mask_i(wr_irq_mask),
	.wdata_i(wdata_i[NI-1:0]),
	.status_o(irq_status),
	.mask_o(irq_mask),
	.irq_o(irq_line)
);

// detector enable; in the awake-only mode sleep turns it off to save power
always @*
begin
	case (brownout_enable_sel_i)
		`RCT_BOR_SEL_OFF: next_bor_en = 1'b0; // see RQ4
		`RCT_BOR_SEL_SW: next_bor_en = software_brownout_enable; // see RQ14
		`RCT_BOR_SEL_AWAKE:
			next_bor_en = (state != ST_SLEEP) && (state != ST_WAKE);
		default: next_bor_en = 1'b1;
	endcase
end

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		// power-on reset itself
		state <= ST_BOOT;
		poweron_flag <= `RCT_RST_POWERON; // see RQ5
		brownout_flag <= `RCT_RST_BROWNOUT; // see RQ2
		software_brownout_enable <= `RCT_RST_SW_BOR_EN; // see RQ12
		ultra_low_power_wake_en_o <= `RCT_RST_ULP_WAKE_EN;
		watchdog_expired_flag <= `RCT_RST_WDOG_EXPIRED; // see RQ10
		sleep_entered_flag <= `RCT_RST_SLEEP_ENTERED;
		pwrt_start <= 1'b0;
		ost_start <= 1'b0;
		events <= {NI{1'b0}};
		chip_reset_o <= 1'b1;
		reset_state_load_o <= 1'b1; // see RQ13
		pc_load_o <= 1'b1;
		pc_low_byte_o <= `RCT_RST_PC_LOW;
		brownout_detect_en_o <= 1'b0;
		irq_o <= 1'b0;
	end
	else
	begin
		pwrt_start <= 1'b0;
		ost_start <= 1'b0;
		events <= {NI{1'b0}};
		reset_state_load_o <= 1'b0;
		pc_load_o <= 1'b0;
		brownout_detect_en_o <= next_bor_en;
		irq_o <= irq_line;
		chip_reset_o <= (state == ST_BOOT) || (state == ST_BOR) ||
			(state == ST_PWRT) || (state == ST_OST) || (state == ST_PIN);
		// software writes first so that a hardware event below overrides them
		if (wr_cause) // see RQ17
		begin
			ultra_low_power_wake_en_o <= wdata_i[`RCT_BIT_ULP_WAKE_EN];
			software_brownout_enable <= wdata_i[`RCT_BIT_SW_BOR_EN];
			poweron_flag <= wdata_i[`RCT_BIT_POWERON]; // see RQ6
			brownout_flag <= wdata_i[`RCT_BIT_BROWNOUT]; // see RQ3
		end
		if (brownout_active)
		begin
			// held for as long as the supply is low, delays start afresh
			state <= ST_BOR; // see RQ18
			brownout_flag <= 1'b0; // see RQ2
			watchdog_expired_flag <= 1'b1; // see RQ10
			sleep_entered_flag <= 1'b1;
			software_brownout_enable <= 1'b1; // see RQ12
			ultra_low_power_wake_en_o <= 1'b0;
			if (state != ST_BOR)
			begin
				events[`RCT_EV_BROWNOUT] <= 1'b1;
				reset_state_load_o <= 1'b1; // see RQ13
				pc_load_o <= 1'b1;
				pc_low_byte_o <= `RCT_RST_PC_LOW;
			end
		end
		else
		begin
			case (state)
				ST_BOR: state <= ST_BOOT;
				ST_BOOT:
				begin
					if (pwrt_en)
					begin
						pwrt_start <= 1'b1;
						state <= ST_PWRT;
					end
					else if (ost_need)
					begin
						ost_start <= 1'b1; // see RQ7
						state <= ST_OST;
					end
					else
					begin
						events[`RCT_EV_STARTUP_DONE] <= 1'b1;
						state <= pin_low ? ST_PIN : ST_RUN;
					end
				end
				ST_PWRT:
				begin
					if (pwrt_done && ost_need)
					begin
						ost_start <= 1'b1; // see RQ7
						state <= ST_OST;
					end
					else if (pwrt_done)
					begin
						events[`RCT_EV_STARTUP_DONE] <= 1'b1;
						state <= pin_low ? ST_PIN : ST_RUN;
					end
				end
				ST_OST:
				begin
					if (ost_done)
					begin
						events[`RCT_EV_STARTUP_DONE] <= 1'b1;
						state <= pin_low ? ST_PIN : ST_RUN;
					end
				end
				ST_RUN:
				begin
					if (pin_low)
					begin
						// cause flags stay as they are
						state <= ST_PIN; // see RQ8
						events[`RCT_EV_PIN_RESET] <= 1'b1;
						ultra_low_power_wake_en_o <= 1'b0; // see RQ12
						reset_state_load_o <= 1'b1; // see RQ13
						pc_load_o <= 1'b1;
						pc_low_byte_o <= `RCT_RST_PC_LOW;
					end
					else if (watchdog_timeout_i)
					begin
						// sleep flag kept; reset is a one-cycle load
						watchdog_expired_flag <= 1'b0; // see RQ11
						events[`RCT_EV_WDOG_RESET] <= 1'b1;
						ultra_low_power_wake_en_o <= 1'b0; // see RQ12
						reset_state_load_o <= 1'b1; // see RQ13
						pc_load_o <= 1'b1;
						pc_low_byte_o <= `RCT_RST_PC_LOW;
					end
					else if (sleep_cmd_i)
					begin
						watchdog_expired_flag <= 1'b1;
						sleep_entered_flag <= 1'b0;
						state <= ST_SLEEP;
					end
					else if (watchdog_clear_i)
					begin
						watchdog_expired_flag <= 1'b1;
						sleep_entered_flag <= 1'b1;
					end
				end
				ST_SLEEP:
				begin
					if (pin_low)
					begin
						watchdog_expired_flag <= 1'b1; // see RQ9
						sleep_entered_flag <= 1'b0;
						state <= ST_PIN;
						events[`RCT_EV_PIN_RESET] <= 1'b1;
						ultra_low_power_wake_en_o <= 1'b0; // see RQ12
						reset_state_load_o <= 1'b1; // see RQ13
						pc_load_o <= 1'b1;
						pc_low_byte_o <= `RCT_RST_PC_LOW;
					end
					else if (watchdog_timeout_i || wake_irq_i)
					begin
						if (watchdog_timeout_i)
						begin
							watchdog_expired_flag <= 1'b0; // see RQ11
							sleep_entered_flag <= 1'b0;
							events[`RCT_EV_WDOG_WAKE] <= 1'b1;
						end
						// wake keeps registers and resumes at the next word
						if (ost_need)
						begin
							ost_start <= 1'b1; // see RQ7
							state <= ST_WAKE;
						end
						else
						begin
							pc_load_o <= 1'b1; // see RQ13
							pc_low_byte_o <= pc_low_i + 8'h01;
							state <= ST_RUN;
						end
					end
				end
				ST_WAKE:
				begin
					if (ost_done)
					begin
						pc_load_o <= 1'b1; // see RQ13
						pc_low_byte_o <= pc_low_i + 8'h01;
						state <= ST_RUN;
					end
				end
				ST_PIN:
				begin
					// delays already expired, so release runs at once
					if (!pin_low)
						state <= ST_RUN;
				end
				default: state <= ST_BOOT;
			endcase
		end
	end
end

// read data one cycle after the strobe; unmapped addresses read zero
always @(posedge clk_i)
begin
	if (rst_i)
		rdata_o <= 8'h00;
	else if (rd_i)
	begin
		rdata_o <= 8'h00;
		case (addr_i)
			`RCT_ADDR_PROC_STATUS:
			begin
				rdata_o[`RCT_BIT_WDOG_EXPIRED] <= watchdog_expired_flag;
				rdata_o[`RCT_BIT_SLEEP_ENTERED] <= sleep_entered_flag;
			end
			`RCT_ADDR_CAUSE_FLAGS:
			begin
				// see RQ1
				rdata_o[`RCT_BIT_ULP_WAKE_EN] <= ultra_low_power_wake_en_o;
				rdata_o[`RCT_BIT_SW_BOR_EN] <= software_brownout_enable;
				rdata_o[`RCT_BIT_POWERON] <= poweron_flag;
				rdata_o[`RCT_BIT_BROWNOUT] <= brownout_flag;
			end
			`RCT_ADDR_IRQ_STATUS: rdata_o[NI-1:0] <= irq_status;
			`RCT_ADDR_IRQ_MASK: rdata_o[NI-1:0] <= irq_mask;
			default: rdata_o <= 8'h00;
		endcase
	end
	else
		rdata_o <= 8'h00;
end

endmodule // rct_top

// file: core/rct_consts.vh
// constants for the reset cause and start-up timeout block
`ifndef RCT_CONSTS_VH
`define RCT_CONSTS_VH

// register byte addresses
`define RCT_ADDR_PROC_STATUS 8'h03
`define RCT_ADDR_CAUSE_FLAGS 8'h8E
`define RCT_ADDR_IRQ_STATUS 8'hF0
`define RCT_ADDR_IRQ_MASK 8'hF1

// processor_status field positions
`define RCT_BIT_WDOG_EXPIRED 4
`define RCT_BIT_SLEEP_ENTERED 3

// reset_cause_flags field positions
`define RCT_BIT_ULP_WAKE_EN 5
`define RCT_BIT_SW_BOR_EN 4
`define RCT_BIT_POWERON 1
`define RCT_BIT_BROWNOUT 0

// reset values of the flags on power-on
`define RCT_RST_POWERON 1'b0
`define RCT_RST_BROWNOUT 1'b0
`define RCT_RST_SW_BOR_EN 1'b1
`define RCT_RST_ULP_WAKE_EN 1'b0
`define RCT_RST_WDOG_EXPIRED 1'b1
`define RCT_RST_SLEEP_ENTERED 1'b1
`define RCT_RST_PC_LOW 8'h00

// brownout_enable_sel encodings
`define RCT_BOR_SEL_OFF 2'h0
`define RCT_BOR_SEL_SW 2'h1
`define RCT_BOR_SEL_AWAKE 2'h2
`define RCT_BOR_SEL_ON 2'h3

// oscillator mode encodings
`define RCT_OSC_LP 3'h0
`define RCT_OSC_XT 3'h1
`define RCT_OSC_HS 3'h2
`define RCT_OSC_EC 3'h3
`define RCT_OSC_INT 3'h4
`define RCT_OSC_RC 3'h5

// timing: power-up timer in ms on the low-frequency oscillator in Hz
`define RCT_TPWRT_MS 64
`define RCT_LFOSC_HZ 31000
`define RCT_OST_PERIODS 1024

// interrupt event bits
`define RCT_IRQ_BITS 5
`define RCT_EV_BROWNOUT 0
`define RCT_EV_WDOG_RESET 1
`define RCT_EV_WDOG_WAKE 2
`define RCT_EV_PIN_RESET 3
`define RCT_EV_STARTUP_DONE 4

`endif

// file: core/rct_delay_cnt.v
// tick counter for the start-up delays, restartable at any time
`timescale 1ns/10ps
module rct_delay_cnt #(
	parameter W = 11,
	parameter [W-1:0] COUNT = 11'h400
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// control
	input wire start_i,
	input wire tick_i,
	// status
	output reg busy_o,
	output reg done_o
);

reg [W-1:0] cnt;

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		cnt <= {W{1'b0}};
		busy_o <= 1'b0;
		done_o <= 1'b0;
	end
	else
	begin
		done_o <= 1'b0;
		if (start_i)
		begin
			// a restart throws away any count already made
			cnt <= {W{1'b0}};
			busy_o <= 1'b1;
		end
		else if (busy_o && tick_i)
		begin
			if (cnt == COUNT - {{(W-1){1'b0}}, 1'b1})
			begin
				busy_o <= 1'b0;
				done_o <= 1'b1;
			end
			else
				cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end
end

endmodule // rct_delay_cnt

// file: core/rct_irq.v
// sticky event status, mask and level interrupt
`timescale 1ns/10ps
module rct_irq #(
	parameter N = 5
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// events
	input wire [N-1:0] set_i,
	// software access
	input wire wr_status_i,
	input wire wr_mask_i,
	input wire [N-1:0] wdata_i,
	// state
	output reg [N-1:0] status_o,
	output reg [N-1:0] mask_o,
	output reg irq_o
);

reg [N-1:0] next_status;

always @*
begin
	next_status = status_o;
	if (wr_status_i)
		next_status = next_status & ~wdata_i;
	// an event in the clearing cycle survives the clear
	next_status = next_status | set_i;
end

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		status_o <= {N{1'b0}};
		mask_o <= {N{1'b0}};
		irq_o <= 1'b0;
	end
	else
	begin
		status_o <= next_status;
		if (wr_mask_i)
			mask_o <= wdata_i;
		irq_o <= |(next_status & (wr_mask_i ? wdata_i : mask_o));
	end
end

endmodule // rct_irq

// file: tb/rct_top_asserts.sv
// port-level assertions for the reset cause and start-up block
`timescale 1ns/10ps
module rct_top_asserts #(
	parameter PWRT_TICKS = 1984,
	parameter OST_TICKS = 1024
) (
	// clock, reset and register port
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	// configuration, time bases and sources
	input wire [1:0] brownout_enable_sel_i,
	input wire powerup_delay_disable_i,
	input wire [2:0] osc_mode_i,
	input wire timer1_osc_input_i,
	input wire lf_tick_i,
	input wire osc_tick_i,
	input wire brownout_below_i,
	input wire external_reset_pin_n_i,
	input wire watchdog_timeout_i,
	input wire wake_irq_i,
	input wire sleep_cmd_i,
	input wire watchdog_clear_i,
	input wire [7:0] pc_low_i,
	// outputs
	input wire chip_reset_o,
	input wire reset_state_load_o,
	input wire pc_load_o,
	input wire [7:0] pc_low_byte_o,
	input wire brownout_detect_en_o,
	input wire ultra_low_power_wake_en_o,
	input wire irq_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its slot");
	chk_unmapped_read: assert property (rd_i && addr_i != 8'h03 &&
		addr_i != 8'h8E && addr_i != 8'hF0 && addr_i != 8'hF1 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_cause_rsvd: assert property (rd_i && addr_i == 8'h8E |=>
		rdata_o[7:6] == 2'h0 && rdata_o[3:2] == 2'h0)
		else $error("unused cause bits not zero");
	chk_pin_reset: assert property ($fell(external_reset_pin_n_i) &&
		!chip_reset_o |-> ##[1:2] chip_reset_o)
		else $error("pin reset not applied");
	chk_bor_load: assert property ($rose(brownout_below_i) &&
		brownout_detect_en_o && !chip_reset_o |=> reset_state_load_o)
		else $error("brownout did not load reset state");
	chk_reset_pc: assert property (reset_state_load_o |->
		pc_load_o && pc_low_byte_o == 8'h00)
		else $error("reset load without zero pc");
	chk_wake_pc: assert property (pc_load_o && !reset_state_load_o |->
		pc_low_byte_o == $past(pc_low_i) + 8'h01)
		else $error("wake pc not advanced by one");
	chk_det_off: assert property (!$past(rst_i) &&
		brownout_enable_sel_i == 2'h0 && $past(brownout_enable_sel_i) == 2'h0
		|-> !brownout_detect_en_o)
		else $error("detector on while disabled");
	chk_det_on: assert property (!$past(rst_i) &&
		brownout_enable_sel_i == 2'h3 && $past(brownout_enable_sel_i) == 2'h3
		|-> brownout_detect_en_o)
		else $error("detector off while forced on");
	chk_por_hold: assert property ($fell(rst_i) |-> chip_reset_o [*2])
		else $error("chip left reset too early");
endmodule // rct_top_asserts
bind rct_top rct_top_asserts #(.PWRT_TICKS(PWRT_TICKS), .OST_TICKS(OST_TICKS))
	i_rct_top_asserts (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.brownout_enable_sel_i(brownout_enable_sel_i),
	.powerup_delay_disable_i(powerup_delay_disable_i),
	.osc_mode_i(osc_mode_i), .timer1_osc_input_i(timer1_osc_input_i),
	.lf_tick_i(lf_tick_i), .osc_tick_i(osc_tick_i),
	.brownout_below_i(brownout_below_i),
	.external_reset_pin_n_i(external_reset_pin_n_i),
	.watchdog_timeout_i(watchdog_timeout_i), .wake_irq_i(wake_irq_i),
	.sleep_cmd_i(sleep_cmd_i), .watchdog_clear_i(watchdog_clear_i),
	.pc_low_i(pc_low_i), .chip_reset_o(chip_reset_o),
	.reset_state_load_o(reset_state_load_o), .pc_load_o(pc_load_o),
	.pc_low_byte_o(pc_low_byte_o), .brownout_detect_en_o(brownout_detect_en_o),
	.ultra_low_power_wake_en_o(ultra_low_power_wake_en_o), .irq_o(irq_o));

// file: tb/rct_top_tb.sv
// self-checking bench for the reset cause and start-up block
`timescale 1ns/10ps
module rct_top_tb;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg [7:0] addr_i = 8'h00;
	reg [7:0] wdata_i = 8'h00;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg [1:0] bsel = 2'h3;
	reg pdis = 1'b0;
	reg [2:0] osc = 3'h1;
	reg t1 = 1'b0;
	reg below = 1'b0;
	reg pin_n = 1'b1;
	reg [3:0] ev = 4'h0;
	reg [7:0] cyc = 8'h00;
	wire [7:0] rdata_o;
	wire [7:0] pcb;
	wire crst, rload, pload, den, ulp, irq;
	integer bad_count = 0;
	integer tests_run = 0;
	integer n;
	integer k;
	reg ok;
	// short counts keep the run brief; bounds below are derived from them
	rct_top #(.PWRT_TICKS(4), .OST_TICKS(3)) i_rct_top (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.brownout_enable_sel_i(bsel), .powerup_delay_disable_i(pdis),
		.osc_mode_i(osc), .timer1_osc_input_i(t1),
		.lf_tick_i(cyc[1:0] == 2'h3), .osc_tick_i(cyc[0]),
		.brownout_below_i(below), .external_reset_pin_n_i(pin_n),
		.watchdog_timeout_i(ev[1]), .wake_irq_i(ev[3]), .sleep_cmd_i(ev[2]),
		.watchdog_clear_i(ev[0]), .pc_low_i(8'h41), .chip_reset_o(crst),
		.reset_state_load_o(rload), .pc_load_o(pload), .pc_low_byte_o(pcb),
		.brownout_detect_en_o(den), .ultra_low_power_wake_en_o(ulp),
		.irq_o(irq));
	initial
		forever #4 clk_i = ~clk_i;
	always @(posedge clk_i)
		cyc <= cyc + 8'h01;
	task print_verdict;
	begin
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task chk(input [63:0] nm, input [7:0] a, input [7:0] s, input [7:0] e);
	begin
		tests_run = tests_run + 1;
		if (s !== e)
		begin
			bad_count = bad_count + 1;
			$display("BAD %0s %h exp %h got %h", nm, a, e, s);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	end
	endtask
	task rd_chk(input [7:0] a, input [7:0] e);
	begin
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk("reg", a, rdata_o, e);
	end
	endtask
	task ev_pulse(input [3:0] v);
	begin
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 4'h0;
	end
	endtask
	task wait_run;
	begin
		n = 0;
		@(posedge clk_i);
		#1;
		while (crst !== 1'b0 && n < 300)
		begin
			@(posedge clk_i);
			#1 n = n + 1;
		end
		chk("run", 8'h00, {7'h00, crst}, 8'h00);
	end
	endtask
	task wait_pc;
	begin
		n = 0;
		#1;
		while (pload !== 1'b1 && n < 300)
		begin
			@(posedge clk_i);
			#1 n = n + 1;
		end
		chk("pc", 8'h00, pcb, 8'h42);
	end
	endtask
	task pin_reset;
	begin
		@(posedge clk_i);
		pin_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1 chk("pin", 8'h00, {7'h00, crst}, 8'h01);
		@(posedge clk_i);
		pin_n <= 1'b1;
		wait_run;
	end
	endtask
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_run;
		chk("delay", 8'h00, {7'h00, n > 13}, 8'h01);
		// table: oscillator modes with and without the power-up timer
		for (k = 0; k < 5; k = k + 1)
		begin
			@(posedge clk_i);
			pdis <= k[0] | k[2];
			osc <= k == 4 ? 3'h0 : k == 3 ? 3'h4 : k == 2 ? 3'h3 :
				k == 1 ? 3'h2 : 3'h1;
			t1 <= k[2];
			rst_i <= 1'b1;
			repeat (6) @(posedge clk_i);
			rst_i <= 1'b0;
			wait_run;
			ok = k == 0 ? n > 13 : k == 1 ? n > 3 && n < 14 : k == 2 ? n > 11 : n < 4;
			chk("delay", k, {7'h00, ok}, 8'h01);
			rd_chk(8'h8E, 8'h10);
			rd_chk(8'h03, 8'h18);
		end
		@(posedge clk_i);
		pdis <= 1'b0;
		osc <= 3'h1;
		t1 <= 1'b0;
		rd_chk(8'h55, 8'h00);
		wr(8'h03, 8'h00);
		rd_chk(8'h03, 8'h18);
		wr(8'h8E, 8'h13);
		rd_chk(8'h8E, 8'h13);
		for (k = 0; k < 4; k = k + 1)
		begin
			@(posedge clk_i);
			bsel <= k[1:0];
			repeat (3) @(posedge clk_i);
			#1 chk("det_en", k, {7'h00, den}, {7'h00, k != 0});
		end
		@(posedge clk_i);
		bsel <= 2'h1;
		wr(8'h8E, 8'h03);
		@(posedge clk_i);
		below <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1 chk("det_en", 8'h01, {6'h00, den, crst}, 8'h00);
		@(posedge clk_i);
		below <= 1'b0;
		bsel <= 2'h3;
		wr(8'h8E, 8'h33);
		#1 chk("ulp", 8'h00, {7'h00, ulp}, 8'h01);
		pin_reset;
		rd_chk(8'h8E, 8'h13);
		rd_chk(8'h03, 8'h18);
		ev_pulse(4'h2);
		#1 chk("load", 8'h00, {7'h00, rload}, 8'h01);
		repeat (3) @(posedge clk_i);
		#1 chk("wdt_run", 8'h00, {7'h00, crst}, 8'h00);
		rd_chk(8'h03, 8'h08);
		rd_chk(8'h8E, 8'h13);
		ev_pulse(4'h1);
		rd_chk(8'h03, 8'h18);
		ev_pulse(4'h4);
		rd_chk(8'h03, 8'h10);
		// watchdog wake, then interrupt wake, both advance the pc
		ev_pulse(4'h2);
		wait_pc;
		chk("ost", 8'h00, {7'h00, n > 3}, 8'h01);
		rd_chk(8'h03, 8'h00);
		ev_pulse(4'h4);
		ev_pulse(4'h8);
		wait_pc;
		rd_chk(8'h03, 8'h10);
		// timer1-fed low-power crystal wakes with no oscillator wait
		@(posedge clk_i);
		osc <= 3'h0;
		t1 <= 1'b1;
		ev_pulse(4'h4);
		ev_pulse(4'h8);
		wait_pc;
		chk("ost", 8'h01, {7'h00, n == 0}, 8'h01);
		@(posedge clk_i);
		osc <= 3'h1;
		t1 <= 1'b0;
		ev_pulse(4'h4);
		pin_reset;
		rd_chk(8'h03, 8'h10);
		rd_chk(8'h8E, 8'h13);
		wr(8'hF0, 8'h1F);
		wr(8'hF1, 8'h01);
		@(posedge clk_i);
		#1 chk("irq", 8'h00, {7'h00, irq}, 8'h00);
		@(posedge clk_i);
		below <= 1'b1;
		repeat (3) @(posedge clk_i);
		below <= 1'b0;
		repeat (8) @(posedge clk_i);
		below <= 1'b1;
		repeat (2) @(posedge clk_i);
		below <= 1'b0;
		wait_run;
		chk("restart", 8'h00, {7'h00, n > 19}, 8'h01);
		rd_chk(8'h8E, 8'h12);
		rd_chk(8'h03, 8'h18);
		wr(8'hF1, 8'h01);
		@(posedge clk_i);
		#1 chk("irq", 8'h01, {7'h00, irq}, 8'h01);
		wr(8'hF0, 8'h01);
		@(posedge clk_i);
		#1 chk("irq", 8'h02, {7'h00, irq}, 8'h00);
		print_verdict;
	end
	// the whole sequence needs well under 2000 cycles
	initial
	begin
		#100000;
		bad_count = bad_count + 1;
		print_verdict;
	end
endmodule // rct_top_tb
